// [logic/pie_top.sv]
// peripheral irq enable register with axi4-lite slave and interrupt gating
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "pie_regs.svh"
module pie_top
  import pie_pkg::*;
#(
  parameter bit HAS_CMP_B = 1'b1
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  input  wire logic        cmp_b_req,
  input  wire logic        cmp_a_req,
  input  wire logic        mem_task_req,
  input  wire logic        freqgen_rollover_req,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [7:0]       periph_irq_req,
  output logic             irq
);
  typedef struct packed {
    pie_byte_t   peripheral_irq_enable_1;
    logic        periph_master_irq_en;
    pie_byte_t   status;
    pie_byte_t   mask;
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic        w_lane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    pie_byte_t   gated;
    logic        irq;
    logic        awready;
    logic        wready;
    logic        arready;
  } pie_state_s;

  pie_state_s st_ff;
  pie_state_s nxt_st;

  pie_gate_if gif ();

  // gate instance sees the enable register and raw requests
  assign gif.raw_req   = {1'b0, cmp_b_req, cmp_a_req, mem_task_req, 3'h0, freqgen_rollover_req};
  assign gif.enable    = st_ff.peripheral_irq_enable_1;
  assign gif.master_en = st_ff.periph_master_irq_en;
  assign gif.has_cmp_b = HAS_CMP_B;

  pie_gate u_gate
  (
    .g (gif.gate)
  );

  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_write;
  logic [7:0] new_ev;

  // channel handshakes; one write and one read outstanding at a time
  assign aw_take  = s_axi_awvalid & st_ff.awready;
  assign w_take   = s_axi_wvalid & st_ff.wready;
  assign ar_take  = s_axi_arvalid & st_ff.arready;
  assign do_write = st_ff.aw_held & st_ff.w_held & ~st_ff.bvalid;
  assign new_ev   = gif.gated & ~st_ff.gated;

  // next state: bus slave, registers, sticky status
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.gated = gif.gated;
    if (aw_take)
    begin
      nxt_st.aw_held = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (w_take)
    begin
      nxt_st.w_held  = 1'b1;
      nxt_st.w_data  = s_axi_wdata;
      nxt_st.w_lane0 = s_axi_wstrb[0];
    end
    if (st_ff.bvalid && s_axi_bready)
      nxt_st.bvalid = 1'b0;
    if (do_write)
    begin
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held  = 1'b0;
      nxt_st.bvalid  = 1'b1;
      nxt_st.bresp   = `PIE_RESP_OKAY;
      case (st_ff.aw_addr)
        `PIE_OFF_ENABLE:
          if (st_ff.w_lane0)
            nxt_st.peripheral_irq_enable_1 = st_ff.w_data[7:0] & `PIE_IMPL_MASK;
        `PIE_OFF_CONTROL:
          if (st_ff.w_lane0)
            nxt_st.periph_master_irq_en = st_ff.w_data[0];
        `PIE_OFF_STATUS:
          if (st_ff.w_lane0)
            nxt_st.status = st_ff.status & ~st_ff.w_data[7:0];
        `PIE_OFF_MASK:
          if (st_ff.w_lane0)
            nxt_st.mask = st_ff.w_data[7:0] & `PIE_IMPL_MASK;
        default:
          nxt_st.bresp = `PIE_RESP_SLVERR;
      endcase
    end
    // new events set status after any clear, so set wins
    nxt_st.status = nxt_st.status | new_ev;
    if (st_ff.rvalid && s_axi_rready)
      nxt_st.rvalid = 1'b0;
    if (ar_take)
    begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = `PIE_RESP_OKAY;
      nxt_st.rdata  = 32'h0000_0000;
      case (s_axi_araddr)
        `PIE_OFF_ENABLE:  nxt_st.rdata[7:0] = st_ff.peripheral_irq_enable_1;
        `PIE_OFF_CONTROL: nxt_st.rdata[0]   = st_ff.periph_master_irq_en;
        `PIE_OFF_STATUS:  nxt_st.rdata[7:0] = st_ff.status;
        `PIE_OFF_MASK:    nxt_st.rdata[7:0] = st_ff.mask;
        default:          nxt_st.rresp      = `PIE_RESP_SLVERR;
      endcase
    end
    nxt_st.irq = |(nxt_st.status & nxt_st.mask);
    // readies come from the next state so each one leaves a flip-flop
    nxt_st.awready = ~nxt_st.aw_held & ~nxt_st.bvalid;
    nxt_st.wready  = ~nxt_st.w_held & ~nxt_st.bvalid;
    nxt_st.arready = ~nxt_st.rvalid;
  end

  // state register, synchronous reset clears every enable
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_ff <= '0;
      st_ff.peripheral_irq_enable_1 <= `PIE_RST_ENABLE;
      st_ff.status <= `PIE_RST_STATUS;
      st_ff.mask   <= `PIE_RST_MASK;
      st_ff.awready <= 1'b1;
      st_ff.wready  <= 1'b1;
      st_ff.arready <= 1'b1;
    end
    else if (clk_en)
      st_ff <= nxt_st;
  end

  // outputs straight from flip-flops
  assign s_axi_awready  = st_ff.awready;
  assign s_axi_wready   = st_ff.wready;
  assign s_axi_bvalid   = st_ff.bvalid;
  assign s_axi_bresp    = st_ff.bresp;
  assign s_axi_arready  = st_ff.arready;
  assign s_axi_rvalid   = st_ff.rvalid;
  assign s_axi_rdata    = st_ff.rdata;
  assign s_axi_rresp    = st_ff.rresp;
  assign periph_irq_req = st_ff.gated;
  assign irq            = st_ff.irq;

  // checks
  a_unimpl_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_ff.peripheral_irq_enable_1 & ~`PIE_IMPL_MASK) == 8'h00)
    else $error("unimplemented enable bit set");
  a_rst_clears: assert property (@(posedge aclk)
    !aresetn |=> st_ff.peripheral_irq_enable_1 == 8'h00)
    else $error("enable not cleared by reset");
  a_cmp_b_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && cmp_b_req && st_ff.peripheral_irq_enable_1[6] && st_ff.periph_master_irq_en
    && HAS_CMP_B |=> periph_irq_req[6])
    else $error("second comparator request not forwarded");
  a_cmp_a_mask: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && !st_ff.peripheral_irq_enable_1[5] |=> !periph_irq_req[5])
    else $error("first comparator request leaked");
  a_mem_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && mem_task_req && st_ff.peripheral_irq_enable_1[4] && st_ff.periph_master_irq_en
    |=> periph_irq_req[4])
    else $error("memory task request not passed");
  a_no_cmp_b: assert property (@(posedge aclk) disable iff (!aresetn)
    !HAS_CMP_B |-> !periph_irq_req[6])
    else $error("absent comparator request seen");
  a_master_off: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && !st_ff.periph_master_irq_en |=> periph_irq_req == 8'h00)
    else $error("request passed with master enable off");
  a_freqgen_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && freqgen_rollover_req && st_ff.peripheral_irq_enable_1[0]
    && st_ff.periph_master_irq_en |=> periph_irq_req[0])
    else $error("rollover request not forwarded");

  // remaining gate directions, one per source
  a_cmp_b_mask: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && !st_ff.peripheral_irq_enable_1[6] |=> !periph_irq_req[6])
    else $error("second comparator request leaked");

  a_cmp_a_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && cmp_a_req && st_ff.peripheral_irq_enable_1[5] && st_ff.periph_master_irq_en
    |=> periph_irq_req[5])
    else $error("first comparator request not forwarded");

  a_mem_mask: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && !st_ff.peripheral_irq_enable_1[4] |=> !periph_irq_req[4])
    else $error("memory task request leaked");

  a_freqgen_mask: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && !st_ff.peripheral_irq_enable_1[0] |=> !periph_irq_req[0])
    else $error("rollover request leaked");

  a_unimpl_req: assert property (@(posedge aclk) disable iff (!aresetn)
    periph_irq_req[7] == 1'b0 && periph_irq_req[3:1] == 3'h0)
    else $error("unimplemented request position active");

  // reset leaves the bus idle and every request low
  a_rst_outputs: assert property (@(posedge aclk)
    !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq && periph_irq_req == 8'h00)
    else $error("outputs not idle after reset");

  a_rst_readies: assert property (@(posedge aclk)
    !aresetn |=> s_axi_awready && s_axi_wready && s_axi_arready)
    else $error("channel readies low after reset");

  // write response stands until the master takes it
  a_bvalid_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");

  a_bresp_stable: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> $stable(s_axi_bresp))
    else $error("write response code changed while pending");

  a_write_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel ready while response pending");

  a_bvalid_timing: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && st_ff.aw_held && st_ff.w_held && !st_ff.bvalid |=> s_axi_bvalid)
    else $error("write response late");

  // read data stands until the master takes it
  a_rvalid_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped early");

  a_rdata_stable: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data changed while pending");

  a_read_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read address ready while data pending");

  a_rvalid_timing: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");

  // sticky status, set wins over a clear, level output follows
  a_status_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && !do_write |=> (st_ff.status & $past(st_ff.status)) == $past(st_ff.status))
    else $error("status bit lost without a clear");

  a_event_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && new_ev != 8'h00 |=> (st_ff.status & $past(new_ev)) == $past(new_ev))
    else $error("event did not set its status bit");

  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    irq == |(st_ff.status & st_ff.mask))
    else $error("interrupt level differs from masked status");

  // clock enable low freezes every register while aresetn is high
  a_freeze: assert property (@(posedge aclk) disable iff (!aresetn)
    !clk_en && aresetn |=> $stable(st_ff))
    else $error("state changed while clock enable low");
endmodule

// [logic/pie_regs.svh]
// register offsets, bit positions and reset values of the peripheral irq enable block
`ifndef PIE_REGS_SVH
`define PIE_REGS_SVH
`define PIE_OFF_ENABLE   8'h00
`define PIE_OFF_CONTROL  8'h04
`define PIE_OFF_STATUS   8'h08
`define PIE_OFF_MASK     8'h0C
`define PIE_BIT_CMP_B    6
`define PIE_BIT_CMP_A    5
`define PIE_BIT_MEM      4
`define PIE_BIT_FREQGEN  0
`define PIE_IMPL_MASK    8'h71
`define PIE_RST_ENABLE   8'h00
`define PIE_RST_CONTROL  8'h00
`define PIE_RST_STATUS   8'h00
`define PIE_RST_MASK     8'h00
`define PIE_RESP_OKAY    2'h0
`define PIE_RESP_SLVERR  2'h2
`endif

// [logic/pie_pkg.sv]
// types shared by the peripheral irq enable block
package pie_pkg;
  typedef logic [7:0] pie_byte_t;
endpackage

// [logic/pie_gate_if.sv]
// interface carrying raw requests and gated requests between gate and top
`timescale 1ns/1ns
interface pie_gate_if;
  logic [7:0] raw_req;
  logic [7:0] enable;
  logic       master_en;
  logic       has_cmp_b;
  logic [7:0] gated;
  modport ctrl (output raw_req, output enable, output master_en, output has_cmp_b, input gated);
  modport gate (input raw_req, input enable, input master_en, input has_cmp_b, output gated);
endinterface

// [logic/pie_gate.sv]
// combinational gate that masks each request by its enable bit
`timescale 1ns/1ns
`include "pie_regs.svh"
module pie_gate
  import pie_pkg::*;
(
  pie_gate_if.gate g
);
  // per-bit gating; bits outside the implemented set never pass
  genvar i;
  localparam pie_byte_t IMPL_MASK = `PIE_IMPL_MASK; // implemented positions as a vector
  for (i = 0; i < 8; i++)
  begin : g_bit
    localparam logic IMPL = IMPL_MASK[i];
    if (i == `PIE_BIT_CMP_B)
    begin : g_cmpb
      // absent second comparator leaves nothing to gate
      assign g.gated[i] = g.raw_req[i] & g.enable[i] & g.has_cmp_b & g.master_en;
    end
    else
    begin : g_other
      assign g.gated[i] = IMPL & g.raw_req[i] & g.enable[i] & g.master_en;
    end
  end
endmodule

// [bench/pie_top_bench.sv]
// self-checking testbench of the peripheral irq enable block
`timescale 1ns/1ns
`include "pie_regs.svh"
module pie_top_bench;
  logic aclk, aresetn, clk_en, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq;
  logic [7:0] awaddr, araddr, periph_irq_req, pirq_nc, raw, en;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  int miscompares, checks, i;
  pie_top u_dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .cmp_b_req(raw[6]),
    .cmp_a_req(raw[5]), .mem_task_req(raw[4]), .freqgen_rollover_req(raw[0]),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .periph_irq_req(periph_irq_req), .irq(irq));
  // variant without the second comparator shares every input
  pie_top #(.HAS_CMP_B(1'b0)) u_dut_nocmp (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .cmp_b_req(raw[6]), .cmp_a_req(raw[5]), .mem_task_req(raw[4]),
    .freqgen_rollover_req(raw[0]), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(), .s_axi_rdata(),
    .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready),
    .periph_irq_req(pirq_nc), .irq());
  // 25 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // expected gated request vector
  function automatic logic [7:0] gate_exp(input logic [7:0] e, input logic [7:0] r,
                                          input logic m);
    gate_exp = m ? (e & r & 8'h71) : 8'h00;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask
  task automatic conclude();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // axi4-lite write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    bit ad;
    bit wd;
    n = 0;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (!ad && awready === 1'b1)
      begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1)
      begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end while (bvalid !== 1'b1 && n < 50);
    r = bresp;
    bready <= 1'b0;
    if (n >= 50)
    begin
      miscompares++;
      conclude();
    end
  endtask
  // axi4-lite read, rready held until rvalid seen
  task automatic rdw(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 50)
    begin
      miscompares++;
      conclude();
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge aclk);
  endtask
  // main sequence
  initial
  begin
    aresetn = 1'b0;
    clk_en  = 1'b1;
    raw     = 8'h00;
    awaddr  = 8'h00;
    awvalid = 1'b0;
    wdata   = 32'h0000_0000;
    wstrb   = 4'hF;
    wvalid  = 1'b0;
    bready  = 1'b0;
    araddr  = 8'h00;
    arvalid = 1'b0;
    rready  = 1'b0;
    miscompares = 0;
    checks = 0;
    void'($urandom(32'h369F));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rdw(`PIE_OFF_ENABLE, rd, rsp);
    chk(rd, 32'h0000_0000);
    chk({30'h0, rsp}, {30'h0, `PIE_RESP_OKAY});
    // master enable on, read back through the control word
    wr(`PIE_OFF_CONTROL, 32'h0000_0001, rsp);
    chk({30'h0, rsp}, {30'h0, `PIE_RESP_OKAY});
    rdw(`PIE_OFF_CONTROL, rd, rsp);
    chk(rd, 32'h0000_0001);
    // random and corner enable values, read back and gating
    for (i = 0; i < 12; i++)
    begin
      en = (i == 0) ? 8'hFF : (i == 1) ? 8'h8E : 8'($urandom);
      wr(`PIE_OFF_ENABLE, {24'hFF_FFFF, en}, rsp);
      rdw(`PIE_OFF_ENABLE, rd, rsp);
      chk(rd, {24'h0, en & 8'h71});
      raw <= (i < 2) ? 8'hFF : 8'($urandom);
      settle();
      chk(periph_irq_req, gate_exp(en, raw, 1'b1));
      chk(pirq_nc, gate_exp(en, raw, 1'b1) & 8'hBF);
    end
    // every source enabled and requesting
    wr(`PIE_OFF_ENABLE, 32'h0000_00FF, rsp);
    raw <= 8'hFF;
    settle();
    chk(periph_irq_req, 32'h0000_0071);
    // clock enable low freezes the gated requests
    clk_en <= 1'b0;
    raw    <= 8'h00;
    settle();
    chk(periph_irq_req, 32'h0000_0071);
    clk_en <= 1'b1;
    settle();
    chk(periph_irq_req, 32'h0000_0000);
    // master enable off blocks everything
    raw <= 8'hFF;
    wr(`PIE_OFF_CONTROL, 32'h0, rsp);
    settle();
    chk(periph_irq_req, gate_exp(8'hFF, raw, 1'b0));
    // a write without its low byte lane leaves the register alone
    wstrb <= 4'h0;
    wr(`PIE_OFF_ENABLE, 32'h0000_0000, rsp);
    chk({30'h0, rsp}, {30'h0, `PIE_RESP_OKAY});
    wstrb <= 4'hF;
    rdw(`PIE_OFF_ENABLE, rd, rsp);
    chk(rd, 32'h0000_0071);
    // sticky status, mask and irq level
    raw <= 8'h00;
    wr(`PIE_OFF_CONTROL, 32'h1, rsp);
    wr(`PIE_OFF_ENABLE, 32'h71, rsp);
    wr(`PIE_OFF_STATUS, 32'hFF, rsp);
    wr(`PIE_OFF_MASK, 32'h01, rsp);
    rdw(`PIE_OFF_MASK, rd, rsp);
    chk(rd, 32'h0000_0001);
    raw <= 8'h01;
    settle();
    chk(irq, 1'b1);
    rdw(`PIE_OFF_STATUS, rd, rsp);
    chk(rd, 32'h1);
    wr(`PIE_OFF_MASK, 32'h00, rsp);
    settle();
    chk(irq, 1'b0);
    raw <= 8'h00;
    wr(`PIE_OFF_MASK, 32'h01, rsp);
    wr(`PIE_OFF_STATUS, 32'h01, rsp);
    settle();
    chk(irq, 1'b0);
    rdw(`PIE_OFF_STATUS, rd, rsp);
    chk(rd, 32'h0);
    // unmapped address answers with an error
    rdw(8'h40, rd, rsp);
    chk({30'h0, rsp}, {30'h0, `PIE_RESP_SLVERR});
    wr(8'h40, 32'hFF, rsp);
    chk({30'h0, rsp}, {30'h0, `PIE_RESP_SLVERR});
    // second reset clears the enable bits
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdw(`PIE_OFF_ENABLE, rd, rsp);
    chk(rd, 32'h0);
    conclude();
  end
endmodule
